/* File: twu_pkg.sv */
// Constants and types for the timer/watchdog unit.
package twu_pkg;

  // Core clock rate and the base counting period of internal_clock/4.
  localparam int CLK_MHZ       = 250;
  localparam int BASE_TICK_NS  = 333;
  localparam int BASE_TICK_CYC = (BASE_TICK_NS * CLK_MHZ) / 1000;
  localparam logic [6:0] TICK_LAST = 7'(BASE_TICK_CYC - 1);

  // Watchdog key bytes written to the low reload register.
  localparam logic [7:0] KEY_FIRST  = 8'haa;
  localparam logic [7:0] KEY_SECOND = 8'h55;

  // Paged I/O page that holds the unit's control registers.
  localparam logic [7:0] IO_PAGE = 8'h00;

  // Values after reset, and the zero values of prescaler and counter.
  localparam logic [7:0]  PRESC_RST  = 8'hff;
  localparam logic [7:0]  RELOAD_RST = 8'hff;
  localparam logic [15:0] COUNT_RST  = 16'hffff;
  localparam logic [7:0]  PRESC_ZERO = 8'h00;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;

  // Event input operating modes.
  typedef enum logic [1:0] {
    IN_EVENT     = 2'h0,
    IN_GATED     = 2'h1,
    IN_TRIGGER   = 2'h2,
    IN_RETRIGGER = 2'h3
  } twu_in_mode_t;

  // Unit operation, one-hot.
  typedef enum logic [1:0] {
    UNIT_TIMER = 2'h1,
    UNIT_WDOG  = 2'h2
  } twu_unit_t;

endpackage

/* File: twu_timer_watchdog.sv */
// Timer/watchdog unit: prescaled 16-bit down-counter with pins and key.
`timescale 1ns/1ps

module twu_timer_watchdog (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Software writes to reload and prescaler registers
  input  wire logic        reload_low_wr,
  input  wire logic        reload_high_wr,
  input  wire logic        presc_wr,
  input  wire logic [7:0]  wr_data,
  // Timer control bits
  input  wire logic        count_run_control,
  input  wire logic        input_pin_enable,
  input  wire logic [1:0]  input_mode_sel,
  input  wire logic        output_pin_enable,
  input  wire logic        output_behaviour_select,
  input  wire logic        output_level_value,
  input  wire logic        timer_function_enable,
  // Alternate function and interrupt routing selects
  input  wire logic        event_pin_af_sel,
  input  wire logic        wave_pin_af_sel,
  input  wire logic        prioritized_source_select,
  input  wire logic        top_level_source_select,
  // Pins
  input  wire logic        timer_event_input,
  output logic             timer_wave_output,
  output logic             timer_wave_output_oe,
  // Events
  output logic             external_interrupt_channel_zero,
  output logic             nmi_request,
  output logic             internal_reset_req,
  // Status
  output logic [15:0]      counter_value,
  output logic             watchdog_active,
  output logic [7:0]       reg_page
);

  ////////////////////////////////////////////////////////////////////
  // State
  ////////////////////////////////////////////////////////////////////

  logic                s1_reg;
  logic                s2_reg;
  logic                s3_reg;
  logic                lvl_reg;
  logic                lvl_next;
  logic [6:0]          tick_reg;
  logic [6:0]          tick_next;
  twu_pkg::twu_unit_t  unit_reg;
  twu_pkg::twu_unit_t  unit_next;
  logic                key_reg;
  logic                key_next;
  logic [7:0]          rlo_reg;
  logic [7:0]          rlo_next;
  logic [7:0]          rhi_reg;
  logic [7:0]          rhi_next;
  logic [7:0]          pset_reg;
  logic [7:0]          pset_next;
  logic [7:0]          presc_reg;
  logic [7:0]          presc_next;
  logic [15:0]         cnt_reg;
  logic [15:0]         cnt_next;
  logic                hold_reg;
  logic                hold_next;
  logic                wave_reg;
  logic                wave_next;
  logic                oe_reg;
  logic                irq0_reg;
  logic                nmi_reg;
  logic                wdrst_reg;

  ////////////////////////////////////////////////////////////////////
  // Event input synchroniser and filter
  ////////////////////////////////////////////////////////////////////

  logic agree;
  logic evt_fall;

  // A new level counts once the second and third stages agree.
  assign agree    = (s2_reg == s3_reg);
  assign lvl_next = agree ? s3_reg : lvl_reg;
  assign evt_fall = agree & lvl_reg & ~s3_reg;

  // Three-stage synchroniser; the idle level of the pin is high.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_reg  <= 1'b1;
      s2_reg  <= 1'b1;
      s3_reg  <= 1'b1;
      lvl_reg <= 1'b1;
    end else begin
      s1_reg  <= timer_event_input;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      lvl_reg <= lvl_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Base tick at internal clock over four
  ////////////////////////////////////////////////////////////////////

  logic tick;

  // One tick per base period gives the 332ns step of the counter.
  assign tick      = (tick_reg == 7'h00);
  assign tick_next = tick ? twu_pkg::TICK_LAST : tick_reg - 7'h01;

  // Free-running divider of the core clock.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_reg <= twu_pkg::TICK_LAST;
    end else begin
      tick_reg <= tick_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Unit operation and watchdog key
  ////////////////////////////////////////////////////////////////////

  logic timer_mode;
  logic wdog_mode;
  logic key_ok;

  assign timer_mode = (unit_reg == twu_pkg::UNIT_TIMER);
  assign wdog_mode  = (unit_reg == twu_pkg::UNIT_WDOG);

  // Watchdog operation is a one-way latch; nothing but reset clears it.
  always_comb begin
    unit_next = unit_reg;
    case (unit_reg)
      twu_pkg::UNIT_TIMER: begin
        if (!timer_function_enable) begin
          unit_next = twu_pkg::UNIT_WDOG;
        end
      end
      twu_pkg::UNIT_WDOG: begin
        unit_next = twu_pkg::UNIT_WDOG;
      end
      default: begin
        unit_next = twu_pkg::UNIT_WDOG;
      end
    endcase
  end

  // Any low reload write rearms or disarms the key; only 0aah arms it,
  // and only in watchdog operation, so timer data cannot half-key it.
  assign key_next = reload_low_wr
                  ? (wdog_mode & (wr_data == twu_pkg::KEY_FIRST))
                  : key_reg;
  assign key_ok   = wdog_mode & reload_low_wr & key_reg
                  & (wr_data == twu_pkg::KEY_SECOND);

  // Mode latch and key state.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      unit_reg <= twu_pkg::UNIT_TIMER;
      key_reg  <= 1'b0;
    end else begin
      unit_reg <= unit_next;
      key_reg  <= key_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Reload and prescaler preset registers
  ////////////////////////////////////////////////////////////////////

  logic [15:0] reload_val;

  // In watchdog operation the low register keeps its value; low writes are key bytes only.
  assign rlo_next   = (reload_low_wr & timer_mode) ? wr_data : rlo_reg;
  assign rhi_next   = reload_high_wr ? wr_data : rhi_reg;
  assign pset_next  = presc_wr ? wr_data : pset_reg;
  assign reload_val = {rhi_reg, rlo_reg};

  // Preset storage written by software.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rlo_reg  <= twu_pkg::RELOAD_RST;
      rhi_reg  <= twu_pkg::RELOAD_RST;
      pset_reg <= twu_pkg::PRESC_RST;
    end else begin
      rlo_reg  <= rlo_next;
      rhi_reg  <= rhi_next;
      pset_reg <= pset_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Counting source selection
  ////////////////////////////////////////////////////////////////////

  logic pin_on;
  logic m_event;
  logic m_gated;
  logic m_trig;
  logic m_retrig;
  logic src;
  logic run;

  // The event input takes part only when enabled and selected.
  assign pin_on   = input_pin_enable & event_pin_af_sel & timer_mode;
  assign m_event  = pin_on & (input_mode_sel == twu_pkg::IN_EVENT);
  assign m_gated  = pin_on & (input_mode_sel == twu_pkg::IN_GATED);
  assign m_trig   = pin_on & (input_mode_sel == twu_pkg::IN_TRIGGER);
  assign m_retrig = pin_on & (input_mode_sel == twu_pkg::IN_RETRIGGER);

  // Prescaler clock: pin edges, gated ticks, or plain ticks.
  assign src = m_event ? evt_fall
             : m_gated ? (tick & lvl_reg)
             : tick;

  // The watchdog always counts; the timer obeys run control.
  assign run = timer_mode ? count_run_control : 1'b1;

  ////////////////////////////////////////////////////////////////////
  // Prescaler and down-counter
  ////////////////////////////////////////////////////////////////////

  logic reload;
  logic pclk;
  logic step;
  logic eoc;

  // Pin reloads need run control; trigger waits for end of count.
  assign reload = (run & evt_fall & (m_retrig | (m_trig & hold_reg)))
                | key_ok;
  assign pclk   = run & src & ~hold_reg;
  assign step   = pclk & (presc_reg == twu_pkg::PRESC_ZERO);
  assign eoc    = step & (cnt_reg == twu_pkg::COUNT_ZERO);

  // Prescaler divides by its preset plus one.
  always_comb begin
    presc_next = presc_reg;
    if (reload) begin
      presc_next = pset_reg;
    end else if (pclk) begin
      if (presc_reg == twu_pkg::PRESC_ZERO) begin
        presc_next = pset_reg;
      end else begin
        presc_next = presc_reg - 8'h01;
      end
    end
  end

  // Counter reloads at end of count except in trigger mode, where it stays at zero.
  always_comb begin
    cnt_next = cnt_reg;
    if (reload) begin
      cnt_next = reload_val;
    end else if (step) begin
      if (cnt_reg != twu_pkg::COUNT_ZERO) begin
        cnt_next = cnt_reg - 16'h0001;
      end else if (!m_trig) begin
        cnt_next = reload_val;
      end
    end
  end

  // Trigger mode parks at zero until the next falling edge.
  assign hold_next = reload ? 1'b0
                   : m_trig ? (hold_reg | eoc)
                   : 1'b0;

  // Count state.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      presc_reg <= twu_pkg::PRESC_RST;
      cnt_reg   <= twu_pkg::COUNT_RST;
      hold_reg  <= 1'b0;
    end else begin
      presc_reg <= presc_next;
      cnt_reg   <= cnt_next;
      hold_reg  <= hold_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Wave output, interrupts and watchdog reset
  ////////////////////////////////////////////////////////////////////

  // Toggle, or copy the level bit, at each timer end of count.
  assign wave_next = (timer_mode & eoc)
                   ? (output_behaviour_select ? output_level_value
                                              : ~wave_reg)
                   : wave_reg;

  // Registered pin drive and event pulses.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wave_reg  <= 1'b0;
      oe_reg    <= 1'b0;
      irq0_reg  <= 1'b0;
      nmi_reg   <= 1'b0;
      wdrst_reg <= 1'b0;
    end else begin
      wave_reg  <= wave_next;
      oe_reg    <= output_pin_enable & wave_pin_af_sel & timer_mode;
      irq0_reg  <= timer_mode & eoc & prioritized_source_select;
      nmi_reg   <= timer_mode & eoc & top_level_source_select;
      wdrst_reg <= wdog_mode & eoc;
    end
  end

  // Outputs. The watchdog reset goes to on-chip reset logic only.
  assign timer_wave_output               = wave_reg;
  assign timer_wave_output_oe            = oe_reg;
  assign external_interrupt_channel_zero = irq0_reg;
  assign nmi_request                     = nmi_reg;
  assign internal_reset_req              = wdrst_reg;
  assign counter_value                   = cnt_reg;
  assign watchdog_active                 = wdog_mode;
  assign reg_page                        = twu_pkg::IO_PAGE;

endmodule

/* File: twu_asserts.sv */
// Checker of the timer/watchdog unit port behaviour.
`timescale 1ns/1ps
module twu_asserts (
  // Clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // Inputs
  input wire logic        reload_low_wr,
  input wire logic        reload_high_wr,
  input wire logic [7:0]  wr_data,
  input wire logic        output_pin_enable,
  input wire logic        wave_pin_af_sel,
  input wire logic        timer_function_enable,
  input wire logic        prioritized_source_select,
  input wire logic        top_level_source_select,
  // Outputs
  input wire logic        timer_wave_output_oe,
  input wire logic        external_interrupt_channel_zero,
  input wire logic        nmi_request,
  input wire logic        internal_reset_req,
  input wire logic [15:0] counter_value,
  input wire logic        watchdog_active,
  input wire logic [7:0]  reg_page
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [15:0] rl_reg;

  // Shadow of the reload value; low writes in watchdog are key only.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rl_reg <= {twu_pkg::RELOAD_RST, twu_pkg::RELOAD_RST};
    end else begin
      if (reload_high_wr) rl_reg[15:8] <= wr_data;
      if (reload_low_wr && !watchdog_active) rl_reg[7:0] <= wr_data;
    end
  end

  a_page_zero: assert property (reg_page == twu_pkg::IO_PAGE)
    else $error("register page is not zero");
  a_oe_gated: assert property (timer_wave_output_oe |->
    $past(output_pin_enable && wave_pin_af_sel))
    else $error("wave pin driven while not enabled");
  a_oe_wdog: assert property ($past(watchdog_active) |->
    !timer_wave_output_oe)
    else $error("wave pin driven in watchdog operation");
  a_wdog_held: assert property ($past(watchdog_active) |->
    watchdog_active)
    else $error("watchdog operation left without reset");
  a_wdog_entry: assert property (!timer_function_enable |->
    ##[0:2] watchdog_active)
    else $error("watchdog operation not entered");
  a_irq_route: assert property (external_interrupt_channel_zero |->
    $past(prioritized_source_select && !watchdog_active))
    else $error("channel zero pulse without its select");
  a_nmi_route: assert property (nmi_request |->
    $past(top_level_source_select && !watchdog_active))
    else $error("nmi pulse without its select");
  a_wdog_reset: assert property (internal_reset_req |->
    $past(watchdog_active) ##1 !internal_reset_req)
    else $error("internal reset outside watchdog or too long");
  a_zero_reload: assert property ($past(counter_value) == 16'h0000 &&
    counter_value != 16'h0000 |-> counter_value == rl_reg)
    else $error("counter left zero without reload value");
  a_key_reload: assert property (
    $past(reload_low_wr && wr_data == twu_pkg::KEY_FIRST, 2) &&
    $past(reload_low_wr && wr_data == twu_pkg::KEY_SECOND) &&
    $past(watchdog_active) |-> counter_value == rl_reg)
    else $error("key sequence did not reload counter");
endmodule

bind twu_timer_watchdog twu_asserts u_chk (.*);

/* File: twu_pin_model.sv */
// Behavioural model of the event input and wave output pins.
`timescale 1ns/1ps
module twu_pin_model (
  // Clock and request
  input  wire logic       clk,
  input  wire logic       start,
  input  wire logic [3:0] n_edges,
  input  wire logic       idle_lvl,
  // Wave pin from the unit
  input  wire logic       wave,
  input  wire logic       wave_oe,
  // Pin levels
  output logic            event_pin,
  output logic            wave_pin,
  output logic            busy
);
  int   left = 0;
  int   ph = 0;
  logic last = 1'b0;

  // Pulses are 50 cycles high, 50 low: falling edges 400 ns apart.
  always @(posedge clk) begin
    if (start) begin
      left = n_edges;
      ph = 0;
    end else if (left > 0) begin
      ph = ph + 1;
      if (ph == 100) begin
        left = left - 1;
        ph = 0;
      end
    end
    event_pin <= (left > 0) ? (ph < 50) : idle_lvl;
    busy <= (left > 0) || start;
    if (wave_oe) last <= wave;
  end

  // A released wave pin shows the inverse of its last driven level.
  assign wave_pin = wave_oe ? wave : ~last;
endmodule

/* File: tb_top.sv */
// Testbench of the timer/watchdog unit.
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0, resetn = 1'b0, start = 1'b0, idle_lvl = 1'b1;
  logic reload_low_wr = 1'b0, reload_high_wr = 1'b0, presc_wr = 1'b0;
  logic [7:0]  wr_data = 8'h00;
  logic [1:0]  input_mode_sel = 2'h3;
  logic [3:0]  n_edges = 4'h1;
  logic [15:0] counter_value, c0;
  logic [7:0]  reg_page;
  logic count_run_control = 1'b0, input_pin_enable = 1'b0;
  logic output_pin_enable = 1'b0, output_behaviour_select = 1'b0;
  logic output_level_value = 1'b0, timer_function_enable = 1'b1;
  logic event_pin_af_sel = 1'b0, wave_pin_af_sel = 1'b0;
  logic prioritized_source_select = 1'b0, top_level_source_select = 1'b0;
  logic timer_event_input, timer_wave_output, timer_wave_output_oe;
  logic external_interrupt_channel_zero, nmi_request, internal_reset_req;
  logic watchdog_active, wave_pin, busy;
  int   err_total = 0, checks_done = 0;

  always #2 clk = ~clk;
  twu_timer_watchdog uut (.*);
  twu_pin_model u_pin (.clk(clk), .start(start), .n_edges(n_edges),
    .idle_lvl(idle_lvl), .wave(timer_wave_output),
    .wave_oe(timer_wave_output_oe), .event_pin(timer_event_input),
    .wave_pin(wave_pin), .busy(busy));

  ////////////////////////////////////////////////////////////////////////
  // Access tasks.
  task automatic stp(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] s, e);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input int r, input logic [7:0] d);
    wr_data = d;
    reload_low_wr = (r == 0);
    reload_high_wr = (r == 1);
    presc_wr = (r == 2);
    stp(1);
    {reload_low_wr, reload_high_wr, presc_wr} = 3'h0;
    stp(1);
  endtask
  task automatic key;
    wr_data = 8'haa;
    reload_low_wr = 1'b1;
    stp(1);
    wr_data = 8'h55;
    stp(1);
    reload_low_wr = 1'b0;
  endtask
  task automatic fire(input logic [3:0] ne, input logic lvl);
    n_edges = ne;
    idle_lvl = lvl;
    start = 1'b1;
    stp(1);
    start = 1'b0;
  endtask
  function automatic logic hit(input int w);
    case (w)
      0: hit = counter_value !== c0;
      1: hit = external_interrupt_channel_zero === 1'b1;
      2: hit = nmi_request === 1'b1;
      3: hit = internal_reset_req === 1'b1;
      default: hit = busy === 1'b0;
    endcase
  endfunction
  task automatic wfor(input int w, output int n);
    c0 = counter_value;
    n = 0;
    while (!hit(w)) begin
      stp(1);
      n++;
      if (n > 8000) begin
        err_total++;
        $display("CHECK FAILED wait %0d expected event seen none", w);
        stop_test();
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    int n;
    logic [15:0] v;
    stp(20);
    resetn = 1'b1;
    stp(1);
    chk("count", counter_value, 16'hffff);
    chk("page", 16'(reg_page), 16'h0000);
    chk("oe", 16'(timer_wave_output_oe), 16'h0000);
    $display("reset test done");
    wr(1, 8'h00);
    wr(0, 8'h05);
    wr(2, 8'hff);
    {input_pin_enable, event_pin_af_sel, count_run_control} = 3'h7;
    fire(1, 0);
    wfor(4, n);
    chk("retrig", counter_value, 16'h0005);
    count_run_control = 1'b0;
    wr(0, 8'h09);
    fire(1, 0);
    wfor(4, n);
    chk("run off", counter_value, 16'h0005);
    count_run_control = 1'b1;
    wr(2, 8'h01);
    fire(1, 0);
    wfor(0, n);
    chk("load", counter_value, 16'h0009);
    wfor(0, n);
    chk("step", counter_value, 16'h0008);
    wfor(0, n);
    chk("period", 16'(n), 16'h00a6);
    $display("retrigger test done");
    wr(2, 8'h00);
    {output_pin_enable, wave_pin_af_sel} = 2'h3;
    prioritized_source_select = 1'b1;
    wfor(1, n);
    chk("eoc load", counter_value, 16'h0009);
    chk("toggle", 16'(wave_pin), 16'h0001);
    {output_behaviour_select, output_level_value} = 2'h3;
    {prioritized_source_select, top_level_source_select} = 2'h1;
    wfor(2, n);
    chk("copy", 16'(wave_pin), 16'h0001);
    chk("irq", 16'(external_interrupt_channel_zero), 16'h0000);
    output_pin_enable = 1'b0;
    stp(2);
    chk("oe off", 16'(timer_wave_output_oe), 16'h0000);
    $display("end of count test done");
    input_mode_sel = 2'h2;
    wfor(2, n);
    stp(200);
    chk("park", counter_value, 16'h0000);
    fire(1, 0);
    wfor(0, n);
    chk("trig", counter_value, 16'h0009);
    input_mode_sel = 2'h1;
    stp(200);
    v = counter_value;
    stp(300);
    chk("gate low", counter_value, v);
    fire(0, 1);
    wfor(0, n);
    chk("gate high", 16'(n < 100), 16'h0001);
    input_mode_sel = 2'h0;
    stp(2);
    v = counter_value;
    fire(3, 1);
    wfor(4, n);
    stp(8);
    repeat (3) v = (v == 16'h0000) ? 16'h0009 : v - 16'h0001;
    chk("events", counter_value, v);
    $display("pin mode test done");
    output_pin_enable = 1'b1;
    wr(1, 8'h00);
    wr(0, 8'h40);
    timer_function_enable = 1'b0;
    stp(3);
    chk("wdog on", 16'(watchdog_active), 16'h0001);
    chk("wdog oe", 16'(timer_wave_output_oe), 16'h0000);
    key();
    chk("key", counter_value, 16'h0040);
    stp(100);
    wr(0, 8'h55);
    chk("lone", 16'(counter_value === 16'h0040), 16'h0000);
    timer_function_enable = 1'b1;
    stp(3);
    chk("wdog held", 16'(watchdog_active), 16'h0001);
    wfor(3, n);
    chk("timeout", counter_value, 16'h0040);
    chk("nmi", 16'(nmi_request), 16'h0000);
    resetn = 1'b0;
    stp(3);
    resetn = 1'b1;
    stp(1);
    chk("timer mode", 16'(watchdog_active), 16'h0000);
    $display("watchdog test done");
    stop_test();
  end
endmodule
